/* File: inc/fss_pkg.sv */
// shared constants and types of the serial memory front end
// assumes: included before the design, referenced as fss_pkg::name
`default_nettype none

package fss_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WRITE_LATCH_CMD    = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH_CMD  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD        = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_CMD       = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE_CMD        = 8'h02;
  localparam logic [7:0] OP_ARRAY_READ_CMD         = 8'h03;
  localparam logic [7:0] OP_FAST_ARRAY_READ_CMD    = 8'h0b;
  localparam logic [7:0] OP_SPECIAL_SECTOR_WRITE_CMD = 8'h42;
  localparam logic [7:0] OP_SPECIAL_SECTOR_READ_CMD  = 8'h4b;
  localparam logic [7:0] OP_DEVICE_ID_READ_CMD     = 8'h9f;
  localparam logic [7:0] OP_UNIQUE_ID_READ_CMD     = 8'h4c;
  localparam logic [7:0] OP_SERIAL_NUMBER_WRITE_CMD = 8'hc2;
  localparam logic [7:0] OP_SERIAL_NUMBER_READ_CMD  = 8'hc3;
  localparam logic [7:0] OP_DEEP_SLEEP_CMD         = 8'hba;
  localparam logic [7:0] OP_HIBERNATE_CMD          = 8'hb9;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int         BYTE_W     = 8;
  localparam int         ADDR_W     = 18;
  localparam int         IDX_W      = 3;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [2:0] IDX_MAX    = 3'h7;
  localparam logic [2:0] HDR_NONE   = 3'h1;  // opcode only
  localparam logic [2:0] HDR_ADDR   = 3'h4;  // opcode and three address bytes
  localparam logic [2:0] HDR_FAST   = 3'h5;  // plus one dummy byte
  localparam logic [2:0] IDX_ADDR_LAST = 3'h3;

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_RESET   = 8'h40;
  localparam logic [7:0] STAT_WR_MASK = 8'h8c;
  localparam int         STAT_WEL_BIT = 1;

  // ----------------------------------------------------------------
  // crossing
  // ----------------------------------------------------------------
  localparam int SYNC_DEPTH = 3;

  // decoded command handed downstream
  typedef struct packed {
    logic [7:0]  opcode;
    logic        mode3;
    logic [17:0] addr;
  } fss_cmd_t;

endpackage : fss_pkg

`default_nettype wire

/* File: design/fss_front_end.sv */
// serial memory front end: frame decode on the serial clock, hand-over on the system clock
// assumes: fss_pkg compiled first; serial clock and chip select come from an outside master
//
// What this block does
// R1: instruction bits are taken only while chip select is low
// R2: deselected, serial input is ignored and serial output floats
// R3: one opcode per selection, starting at chip select falling
// R4: sample input on rising clock, change output on falling clock
// R5: first rising edge after selection brings the opcode's top bit
// R6: all bytes travel most significant bit first
// R7: three address bytes, first six bits dropped, eighteen bits kept
// R8: master should send zeros in the dropped address bits
// R9: first complete byte after selection is the opcode
// R10: bad opcode: no action, input ignored, output floats until reselection
// R11: clock level at selection picks mode 0 or mode 3
// R12: mode 3 capture starts at the first rising edge after the toggle
// R13: master parks the clock low in mode 0, high in mode 3
// R14: master waits the power-up time before first selection
// R15: fifteen defined opcodes, each one function
// R16: master keeps plain and special-sector reads at or under 40 MHz
// R17: any other opcode takes the bad-opcode path
// R18: eight-bit status and configuration register held inside
// R19: master may join input and output as one three-wire line
// R20: output driven only while read data is returned
// R21: master deselects after each operation before a new opcode
// R22: decoded opcode, address and frame end delivered downstream
`default_nettype none

module fss_front_end (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             spi_clk_i,
  input  wire logic             cs_n_i,
  input  wire logic             si_i,
  input  wire logic [7:0]       rd_data_i,
  output logic                  so_o,
  output logic                  so_oe_n_o,
  output fss_pkg::fss_cmd_t     cmd_o,
  output logic                  cmd_valid_o,
  output logic                  addr_valid_o,
  output logic [7:0]            rx_data_o,
  output logic                  rx_valid_o,
  output logic                  tx_take_o,
  output logic                  frame_end_o,
  output logic [7:0]            status_o
);

  // ----------------------------------------------------------------
  // opcode decoding
  // ----------------------------------------------------------------
  // defined opcodes, all others reserved
  function automatic logic op_known(input logic [7:0] op);
    unique case (op)
      fss_pkg::OP_SET_WRITE_LATCH_CMD, fss_pkg::OP_CLEAR_WRITE_LATCH_CMD,
      fss_pkg::OP_STATUS_READ_CMD, fss_pkg::OP_STATUS_WRITE_CMD,
      fss_pkg::OP_ARRAY_WRITE_CMD, fss_pkg::OP_ARRAY_READ_CMD,
      fss_pkg::OP_FAST_ARRAY_READ_CMD, fss_pkg::OP_SPECIAL_SECTOR_WRITE_CMD,
      fss_pkg::OP_SPECIAL_SECTOR_READ_CMD, fss_pkg::OP_DEVICE_ID_READ_CMD,
      fss_pkg::OP_UNIQUE_ID_READ_CMD, fss_pkg::OP_SERIAL_NUMBER_WRITE_CMD,
      fss_pkg::OP_SERIAL_NUMBER_READ_CMD, fss_pkg::OP_DEEP_SLEEP_CMD,
      fss_pkg::OP_HIBERNATE_CMD: op_known = 1'b1; // R15
      default: op_known = 1'b0; // R17
    endcase
  endfunction : op_known

  // bytes before the data phase, opcode included
  function automatic logic [2:0] op_hdr(input logic [7:0] op);
    unique case (op)
      fss_pkg::OP_ARRAY_WRITE_CMD, fss_pkg::OP_ARRAY_READ_CMD,
      fss_pkg::OP_SPECIAL_SECTOR_WRITE_CMD,
      fss_pkg::OP_SPECIAL_SECTOR_READ_CMD: op_hdr = fss_pkg::HDR_ADDR;
      fss_pkg::OP_FAST_ARRAY_READ_CMD: op_hdr = fss_pkg::HDR_FAST;
      default: op_hdr = fss_pkg::HDR_NONE;
    endcase
  endfunction : op_hdr

  // opcodes whose data phase returns bytes
  function automatic logic op_reads(input logic [7:0] op);
    unique case (op)
      fss_pkg::OP_STATUS_READ_CMD, fss_pkg::OP_ARRAY_READ_CMD,
      fss_pkg::OP_FAST_ARRAY_READ_CMD, fss_pkg::OP_SPECIAL_SECTOR_READ_CMD,
      fss_pkg::OP_DEVICE_ID_READ_CMD, fss_pkg::OP_UNIQUE_ID_READ_CMD,
      fss_pkg::OP_SERIAL_NUMBER_READ_CMD: op_reads = 1'b1;
      default: op_reads = 1'b0;
    endcase
  endfunction : op_reads

  // opcodes after which the write latch drops
  function automatic logic op_drops_wel(input logic [7:0] op);
    unique case (op)
      fss_pkg::OP_CLEAR_WRITE_LATCH_CMD, fss_pkg::OP_STATUS_WRITE_CMD,
      fss_pkg::OP_ARRAY_WRITE_CMD, fss_pkg::OP_SPECIAL_SECTOR_WRITE_CMD,
      fss_pkg::OP_SERIAL_NUMBER_WRITE_CMD: op_drops_wel = 1'b1;
      default: op_drops_wel = 1'b0;
    endcase
  endfunction : op_drops_wel

  // ----------------------------------------------------------------
  // link side, serial clock domain
  // ----------------------------------------------------------------
  logic              frame_rst;
  logic [2:0]        bit_cnt_r;
  logic [2:0]        byte_idx_r;
  logic [6:0]        shift_r;
  logic [7:0]        op_r;
  logic              bad_r;
  logic              rd_act_r;
  logic [17:0]       addr_r;
  logic [7:0]        ev_byte_r;
  logic [2:0]        ev_idx_r;
  logic              ev_tgl_r;
  logic              mode3_r;
  logic [7:0]        in_byte;
  logic [7:0]        cur_op;
  logic [6:0]        tx_sh_r;
  logic [7:0]        tx_hold_r;

  // deselection or system reset clears the frame
  assign frame_rst = cs_n_i | reset_i; // R2
  assign in_byte   = {shift_r, si_i}; // R6
  assign cur_op    = (byte_idx_r == 3'h0) ? in_byte : op_r;

  // clock level at selection picks the mode
  always_ff @(negedge cs_n_i or posedge reset_i) begin
    if (reset_i) begin
      mode3_r <= 1'b0;
    end else begin
      mode3_r <= spi_clk_i; // R11
    end
  end

  // bit and byte framing, opcode capture and read-phase start
  always_ff @(posedge spi_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_r  <= 3'h0;
      byte_idx_r <= 3'h0;
      shift_r    <= 7'h00;
      op_r       <= 8'h00;
      bad_r      <= 1'b0;
      rd_act_r   <= 1'b0;
    end else if (!bad_r) begin // R10
      // counting starts at the first rising edge, so a mode 3 park-high is skipped
      bit_cnt_r <= bit_cnt_r + 3'h1; // R4 R12
      shift_r   <= in_byte[6:0]; // R5
      if (bit_cnt_r == fss_pkg::BIT_LAST) begin
        if (byte_idx_r != fss_pkg::IDX_MAX) begin
          byte_idx_r <= byte_idx_r + 3'h1;
        end
        if (byte_idx_r == 3'h0) begin
          op_r  <= in_byte; // R9 R3
          bad_r <= !op_known(in_byte); // R10 R17
        end
        if (op_known(cur_op) && op_reads(cur_op) &&
            (byte_idx_r + 3'h1 >= op_hdr(cur_op))) begin
          rd_act_r <= 1'b1; // R20
        end
      end
    end
  end

  // byte events toward the system side, kept across frames
  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_tgl_r  <= 1'b0;
      ev_byte_r <= 8'h00;
      ev_idx_r  <= 3'h0;
      addr_r    <= '0;
    end else if (!cs_n_i && !bad_r && bit_cnt_r == fss_pkg::BIT_LAST) begin // R1
      if (op_known(cur_op)) begin
        ev_tgl_r  <= !ev_tgl_r;
        ev_byte_r <= in_byte;
        ev_idx_r  <= byte_idx_r;
      end
      if (byte_idx_r != 3'h0 && byte_idx_r <= fss_pkg::IDX_ADDR_LAST) begin
        addr_r <= {addr_r[9:0], in_byte}; // R7
      end
    end
  end

  // read data leaves on falling edges, top bit first
  always_ff @(negedge spi_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      so_o      <= 1'b0;
      so_oe_n_o <= 1'b1; // R2
      tx_sh_r   <= 7'h00;
    end else if (rd_act_r && !bad_r) begin // R20 R10
      so_oe_n_o <= 1'b0;
      if (bit_cnt_r == 3'h0) begin
        so_o    <= tx_hold_r[7]; // R4 R6
        tx_sh_r <= tx_hold_r[6:0];
      end else begin
        so_o    <= tx_sh_r[6];
        tx_sh_r <= {tx_sh_r[5:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // system side, clock_i domain
  // ----------------------------------------------------------------
  logic [1:0]        sync_r [fss_pkg::SYNC_DEPTH];
  logic              cs_acc_r;
  logic              ev_acc_r;
  logic              cs_rise;
  logic              ev_new;
  logic              op_act_r;
  logic [7:0]        stat_r;
  logic [2:0]        hdr;

  // three-stage synchronisers for chip select and the byte toggle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      for (int i = 0; i < fss_pkg::SYNC_DEPTH; i++) begin
        sync_r[i] <= 2'h1;
      end
    end else begin
      sync_r[0] <= {ev_tgl_r, cs_n_i};
      for (int i = 1; i < fss_pkg::SYNC_DEPTH; i++) begin
        sync_r[i] <= sync_r[i - 1];
      end
    end
  end

  // a change counts once the second and third stages agree
  assign cs_rise = (sync_r[1][0] == sync_r[2][0]) && sync_r[2][0] && !cs_acc_r;
  assign ev_new  = (sync_r[1][1] == sync_r[2][1]) && (sync_r[2][1] != ev_acc_r);
  assign hdr     = op_hdr(cmd_o.opcode);

  // accepted levels
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cs_acc_r <= 1'b1;
      ev_acc_r <= 1'b0;
    end else begin
      if (sync_r[1][0] == sync_r[2][0]) begin
        cs_acc_r <= sync_r[2][0];
      end
      if (ev_new) begin
        ev_acc_r <= sync_r[2][1];
      end
    end
  end

  // decoded command and per-byte strobes
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cmd_o        <= '0;
      cmd_valid_o  <= 1'b0;
      addr_valid_o <= 1'b0;
      rx_data_o    <= 8'h00;
      rx_valid_o   <= 1'b0;
      tx_take_o    <= 1'b0;
      frame_end_o  <= 1'b0;
      op_act_r     <= 1'b0;
    end else begin
      cmd_valid_o  <= 1'b0;
      addr_valid_o <= 1'b0;
      rx_valid_o   <= 1'b0;
      tx_take_o    <= 1'b0;
      frame_end_o  <= cs_rise; // R22
      // a byte landing with the frame end is still handed over
      if (ev_new && ev_idx_r == 3'h0) begin
        cmd_o.opcode <= ev_byte_r; // R22
        cmd_o.mode3  <= mode3_r;
        cmd_valid_o  <= 1'b1;
        op_act_r     <= 1'b1;
      end else if (ev_new && op_act_r) begin
        if (ev_idx_r == fss_pkg::IDX_ADDR_LAST && hdr != fss_pkg::HDR_NONE) begin
          cmd_o.addr   <= addr_r; // R7 R22
          addr_valid_o <= 1'b1;
        end
        if (ev_idx_r >= hdr - 3'h1) begin
          tx_take_o <= op_reads(cmd_o.opcode) && ev_idx_r >= hdr;
        end
        if (ev_idx_r >= hdr && !op_reads(cmd_o.opcode)) begin
          rx_data_o  <= ev_byte_r;
          rx_valid_o <= 1'b1;
        end
      end
      if (cs_rise) begin
        op_act_r <= 1'b0;
      end
    end
  end

  // status and configuration register with write latch
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stat_r <= fss_pkg::STAT_RESET; // R18
    end else begin
      // data byte of a latched status write; the latch bit lies outside the mask
      if (ev_new && op_act_r && ev_idx_r == 3'h1 && stat_r[fss_pkg::STAT_WEL_BIT] &&
          cmd_o.opcode == fss_pkg::OP_STATUS_WRITE_CMD) begin
        stat_r <= (stat_r & ~fss_pkg::STAT_WR_MASK) | (ev_byte_r & fss_pkg::STAT_WR_MASK); // R18
      end
      if (ev_new && ev_idx_r == 3'h0 &&
          ev_byte_r == fss_pkg::OP_SET_WRITE_LATCH_CMD) begin
        stat_r[fss_pkg::STAT_WEL_BIT] <= 1'b1;
      end
      // frame end clears the latch last, so a late data byte is not lost
      if (cs_rise && op_act_r && op_drops_wel(cmd_o.opcode)) begin
        stat_r[fss_pkg::STAT_WEL_BIT] <= 1'b0;
      end
    end
  end

  // next outgoing byte: downstream data for an active read opcode other than status read, else status
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_hold_r <= fss_pkg::STAT_RESET;
      status_o  <= fss_pkg::STAT_RESET;
    end else begin
      status_o <= stat_r;
      if (op_act_r && op_reads(cmd_o.opcode) &&
          cmd_o.opcode != fss_pkg::OP_STATUS_READ_CMD) begin
        tx_hold_r <= rd_data_i;
      end else begin
        tx_hold_r <= stat_r;
      end
    end
  end

endmodule : fss_front_end

`default_nettype wire

/* File: bench/fss_front_end_chk.sv */
// checker: link and hand-over timing of the front end
// assumes: bound to fss_front_end, fss_pkg compiled first
`default_nettype none

module fss_front_end_chk (
  input wire logic              clock_i,
  input wire logic              reset_i,
  input wire logic              spi_clk_i,
  input wire logic              cs_n_i,
  input wire logic              so_o,
  input wire logic              so_oe_n_o,
  input wire fss_pkg::fss_cmd_t cmd_o,
  input wire logic              cmd_valid_o,
  input wire logic              addr_valid_o,
  input wire logic              rx_valid_o,
  input wire logic              tx_take_o,
  input wire logic              frame_end_o
);
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  // read-type opcode in the command register
  sequence rd_op_s;
    cmd_o.opcode inside {8'h05, 8'h03, 8'h0b, 8'h4b, 8'h9f, 8'h4c, 8'hc3};
  endsequence

  float_idle_a: assert property (cs_n_i [*2] |-> so_oe_n_o)
    else $error("output enabled while deselected");
  change_low_a: assert property (!cs_n_i && $past(!cs_n_i) && $changed(so_o) |-> !spi_clk_i)
    else $error("output changed outside a low clock phase");
  enable_read_a: assert property ($fell(so_oe_n_o) |-> ##[0:4] rd_op_s)
    else $error("output enabled for a non-read opcode");
  oe_hold_a: assert property ($rose(so_oe_n_o) |-> cs_n_i)
    else $error("output released while still selected");
  cmd_known_a: assert property (cmd_valid_o |-> cmd_o.opcode inside {8'h06, 8'h04,
      8'h05, 8'h01, 8'h02, 8'h03, 8'h0b, 8'h42, 8'h4b, 8'h9f, 8'h4c, 8'hc2, 8'hc3,
      8'hba, 8'hb9})
    else $error("command event for an undefined opcode");
  cmd_selected_a: assert property (cmd_valid_o |-> !$past(cs_n_i, 5))
    else $error("command event without selection");
  addr_kind_a: assert property (addr_valid_o |-> cmd_o.opcode inside {8'h02, 8'h03,
      8'h0b, 8'h42, 8'h4b})
    else $error("address event for an opcode without address");
  end_deselect_a: assert property (frame_end_o |-> cs_n_i && $past(cs_n_i, 2))
    else $error("frame end while selected");
  rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("receive strobe longer than one cycle");
  take_pulse_a: assert property (tx_take_o |=> !tx_take_o)
    else $error("take strobe longer than one cycle");
endmodule : fss_front_end_chk

bind fss_front_end fss_front_end_chk chk_u (.clock_i(clock_i), .reset_i(reset_i),
  .spi_clk_i(spi_clk_i), .cs_n_i(cs_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
  .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .addr_valid_o(addr_valid_o),
  .rx_valid_o(rx_valid_o), .tx_take_o(tx_take_o), .frame_end_o(frame_end_o));

`default_nettype wire

/* File: bench/fss_spi_master.sv */
// partner: serial bus master, clock stands still between frames
// assumes: 80 ns serial clock, frames started by the bench
`default_nettype none

module fss_spi_master (
  output logic      spi_clk_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // frame driver
  // --------------------
  logic [7:0] rx_r;
  logic       drv_r;
  logic       three_wire = 1'b0; // input and output joined as one line

  initial begin
    spi_clk_o = 1'b0;
    cs_n_o    = 1'b1;
    si_o      = 1'b0;
  end

  // n bytes from the top of tx, msb first; mode from idle clock level
  task automatic xfer(input logic m3, input int n, input logic [47:0] tx);
    spi_clk_o = m3;
    #40 cs_n_o = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      #40 spi_clk_o = 1'b0;
      // shared line: past the opcode the device's output is what the input sees
      #1 si_o = (three_wire && i >= 8) ? so_i : tx[47 - i];
      #39 spi_clk_o = 1'b1;
      rx_r = {rx_r[6:0], so_i};
      drv_r = (i % 8 == 0) ? !so_oe_n_i : drv_r & !so_oe_n_i;
    end
    #40 spi_clk_o = m3;
    #40 cs_n_o = 1'b1;
    si_o = ~si_o; // released line shows no stale value
    #80;
  endtask : xfer
endmodule : fss_spi_master

`default_nettype wire

/* File: bench/fss_front_end_tb_top.sv */
// testbench: frames from the master model, hand-over seen on the system side
// assumes: fss_pkg, design, checker and master model compiled first
`default_nettype none

module fss_front_end_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // harness
  // --------------------
  logic              clock_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              sck, cs_n, si, so, so_oe_n, cmd_v, addr_v, rx_v, tx_take, frame_end;
  logic [7:0]        rd_data = 8'h00;
  logic [7:0]        rx_data, status;
  fss_pkg::fss_cmd_t cmd;
  int                failures, checked, n_cmd, n_addr, n_rx, n_tx, n_end;

  always #10 clock_i = ~clock_i;

  fss_front_end dut_u (.clock_i(clock_i), .reset_i(reset_i), .spi_clk_i(sck),
    .cs_n_i(cs_n), .si_i(si), .rd_data_i(rd_data), .so_o(so), .so_oe_n_o(so_oe_n),
    .cmd_o(cmd), .cmd_valid_o(cmd_v), .addr_valid_o(addr_v), .rx_data_o(rx_data),
    .rx_valid_o(rx_v), .tx_take_o(tx_take), .frame_end_o(frame_end), .status_o(status));

  fss_spi_master master_u (.spi_clk_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
    .so_oe_n_i(so_oe_n));

  // event counts on the system side
  always @(posedge clock_i) begin
    n_cmd  += (cmd_v === 1'b1);
    n_addr += (addr_v === 1'b1);
    n_rx   += (rx_v === 1'b1);
    n_tx   += (tx_take === 1'b1);
    n_end  += (frame_end === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic frame(input logic m3, input int n, input logic [47:0] tx);
    // start just after an edge so no link change meets a system clock edge
    @(posedge clock_i);
    #1;
    {n_cmd, n_addr, n_rx, n_tx, n_end} = '0;
    master_u.xfer(m3, n, tx);
    repeat (10) @(posedge clock_i);
  endtask : frame

  // --------------------
  // scenarios
  // --------------------
  task automatic status_read(input logic m3, input logic [7:0] exp);
    frame(m3, 2, {8'h05, 40'h0});
    chk(n_cmd, 1);
    chk(cmd.mode3, m3);
    chk(master_u.rx_r, exp);
    chk(master_u.drv_r, 1'b1);
    chk(status, exp);
    chk(n_end, 1);
  endtask : status_read

  task automatic status_write;
    frame(0, 2, {8'h01, 8'h8c, 32'h0});
    status_read(0, 8'h40);
    frame(0, 1, {8'h06, 40'h0});
    frame(0, 2, {8'h01, 8'hff, 32'h0});
    chk(n_rx, 1);
    status_read(0, 8'hcc);
  endtask : status_write

  task automatic write_frame;
    frame(0, 5, {8'h02, 24'hab_cdef, 8'h96, 8'h00});
    chk(n_addr, 1);
    chk(cmd.addr, 18'h3cdef);
    chk(n_rx, 1);
    chk(rx_data, 8'h96);
    chk(master_u.drv_r, 1'b0);
  endtask : write_frame

  task automatic fast_read;
    @(posedge clock_i);
    #1 rd_data = 8'h5a;
    frame(0, 6, {8'h0b, 24'h00_0010, 8'h00, 8'h00});
    chk(cmd.addr, 18'h00010);
    chk(n_tx, 1);
    chk(master_u.rx_r, 8'h5a);
  endtask : fast_read

  task automatic bad_opcodes;
    logic [7:0] ops [4] = '{8'h00, 8'h07, 8'hff, 8'h0a};
    foreach (ops[i]) begin
      frame(i[0], 4, {ops[i], 8'h05, 8'h03, 8'h0b, 16'h0});
      chk(n_cmd + n_addr + n_rx + n_tx, 0);
      chk(master_u.drv_r, 1'b0);
    end
  endtask : bad_opcodes

  task automatic all_opcodes;
    logic [7:0] ops [15] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0b,
                             8'h42, 8'h4b, 8'h9f, 8'h4c, 8'hc2, 8'hc3, 8'hba, 8'hb9};
    foreach (ops[i]) begin
      frame(i[0], 1, {ops[i], 40'h0});
      chk(n_cmd, 1);
      chk(cmd.opcode, ops[i]);
    end
  endtask : all_opcodes

  // main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge clock_i);
    status_read(0, 8'h40);
    frame(1, 1, {8'h06, 40'h0});
    master_u.three_wire = 1'b1;
    status_read(1, 8'h42);
    master_u.three_wire = 1'b0;
    write_frame();
    status_read(0, 8'h40);
    status_write();
    fast_read();
    bad_opcodes();
    all_opcodes();
    end_of_test();
  end

  // watchdog
  initial begin
    #1_000_000;
    failures++;
    end_of_test();
  end
endmodule : fss_front_end_tb_top

`default_nettype wire
